//--- cantx_regs.vh
// register offsets, field layout, reset values and timing counts of the
// transmit signal packer; included by every design file, defines only
`ifndef CANTX_REGS_VH
`define CANTX_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CANTX_CTRL_OFS 10'h000
`define CANTX_PGN_OFS 10'h004
`define CANTX_RATE_OFS 10'h008
`define CANTX_LINSEL_OFS 10'h00c
`define CANTX_STAT_OFS 10'h010
`define CANTX_REQ_OFS 10'h014
`define CANTX_MEM_BASE 10'h100
`define CANTX_MEM_TOP 10'h17c

// ----------------------------------------------------------------------
// per-signal memory words and field layout of the position word
// ----------------------------------------------------------------------
`define CANTX_W_POS 2'h0
`define CANTX_W_GAIN 2'h1
`define CANTX_W_OFS 2'h2
`define CANTX_F_TYPE 1:0
`define CANTX_F_SRC 7:4
`define CANTX_F_SIZE 13:8
`define CANTX_F_BYTE 19:16
`define CANTX_F_BIT 23:20
`define CANTX_T_UNDEF 2'h0
`define CANTX_T_DISC 2'h1
`define CANTX_T_CONT 2'h2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CANTX_POS_RST 32'h00110100
`define CANTX_GAIN_RST 32'h00010000
`define CANTX_OFS_RST 32'h00000000
`define CANTX_PGN_RST 18'h0ff01
`define CANTX_RATE_RST 16'h03e8
`define CANTX_PGN_RSVD 18'h0ef00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CANTX_CLK_MHZ 200
`define CANTX_MS_NS 1000000
`define CANTX_CLK_NS 5
`define CANTX_MS_CYC (`CANTX_MS_NS / `CANTX_CLK_NS)

`endif

//--- cantx_cfg_mem.v
// per-signal configuration store: eight slots of four words each, the packer reads five
// assumes one writer/reader at a time, chosen by the packer top
`timescale 1ns/1ps
`include "cantx_regs.vh"

module cantx_cfg_mem (
  input wire ref_clk,
  input wire rst_n,
  input wire [4:0] addr,
  input wire we,
  input wire [31:0] wdata,
  output reg [31:0] q_reg
);

  reg [31:0] mem [0:31];
  integer i;

  // ----------------------------------------------------------------------
  // storage with reset defaults, registered read port
  // ----------------------------------------------------------------------
  // reset loads defaults so an untouched slot encodes as unused
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 32; i = i + 1)
      begin
        if (i[1:0] == `CANTX_W_POS)
          mem[i] <= `CANTX_POS_RST;
        else if (i[1:0] == `CANTX_W_GAIN)
          mem[i] <= `CANTX_GAIN_RST;
        else
          mem[i] <= `CANTX_OFS_RST;
      end
      q_reg <= 32'h00000000;
    end
    else
    begin
      if (we)
        mem[addr] <= wdata;
      q_reg <= mem[addr];
    end
  end

endmodule // cantx_cfg_mem

//--- cantx_packer.v
// transmit frame packer: builds one 8-byte data field from five signals
// assumes fb_* and lin_* come from logic on ref_clk; avalon-mm slave
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "cantx_regs.vh"

module cantx_packer #(
  parameter MS_CYCLES = `CANTX_MS_CYC
) (
  input wire ref_clk,
  input wire arst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [255:0] fb_data,
  input wire [7:0] fb_defined,
  input wire lin_frame_done,
  input wire [4:0] lin_frame_num,
  output wire tx_valid,
  input wire tx_ready,
  output reg [17:0] tx_pgn,
  output reg [63:0] tx_data
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // first frame bit of a field; positions already checked to be 1..8
  function [5:0] start_bit;
    input [31:0] pos;
    begin
      start_bit = {pos[18:16] - 3'h1, pos[22:20] - 3'h1};
    end
  endfunction

  // placement is legal only if the whole field lands inside bits 0..63
  function pos_ok;
    input [31:0] pos;
    reg [6:0] last;
    begin
      last = {1'b0, start_bit(pos)} + {1'b0, pos[13:8]} - 7'h01;
      pos_ok = (pos[19:16] >= 4'h1) && (pos[19:16] <= 4'h8) &&
               (pos[23:20] >= 4'h1) && (pos[23:20] <= 4'h8) &&
               (pos[13:8] >= 6'h01) && (pos[13:8] <= 6'h20) &&
               (last <= 7'h3f);
    end
  endfunction

  // ones in the low size bits
  function [63:0] low_ones;
    input [5:0] size;
    begin
      low_ones = (64'h1 << size) - 64'h1;
    end
  endfunction

  // top of the continuous range: 0xfa then ones, one below all-ones if short
  function [31:0] sat_max;
    input [5:0] size;
    reg [63:0] m;
    begin
      if (size >= 6'h08)
        m = (64'hfb << (size - 6'h08)) - 64'h1;
      else
        m = low_ones(size) - 64'h1;
      sat_max = m[31:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_n_reg;
  wire rst_n;

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_n_reg;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam B_IDLE = 2'h0;
  localparam B_MEM = 2'h1;
  localparam B_ACK = 2'h2;
  localparam P_IDLE = 3'h0;
  localparam P_FETCH = 3'h1;
  localparam P_LOAD = 3'h2;
  localparam P_CALC = 3'h3;
  localparam P_MERGE = 3'h4;
  localparam P_SEND = 3'h5;

  reg [1:0] b_state_reg;
  reg [2:0] p_state_reg;
  reg en_reg;
  reg [17:0] pgn_reg;
  reg [15:0] rate_reg;
  reg [4:0] lin_sel_reg;
  reg pgn_rej_reg;
  reg pend_reg;
  reg [31:0] ms_cnt_reg;
  reg [15:0] rate_cnt_reg;
  reg [255:0] snap_reg;
  reg [7:0] snap_def_reg;
  reg [2:0] sig_reg;
  reg [1:0] word_reg;
  reg [31:0] pos_reg;
  reg [31:0] gain_reg;
  reg [31:0] ofs_reg;
  reg [31:0] code_reg;
  reg [63:0] frame_reg;
  wire [31:0] mem_q;
  reg [4:0] mem_addr;
  reg mem_we;
  wire req;
  wire in_mem;
  wire pk_idle;
  wire bus_mem_go;
  wire sw_req;
  wire ms_tick;
  wire per_trig;
  wire lin_trig;
  wire accept;
  wire [3:0] src;
  wire [31:0] val;
  wire val_def;

  assign req = avs_read | avs_write;
  assign in_mem = (avs_address >= `CANTX_MEM_BASE) &&
                  (avs_address <= `CANTX_MEM_TOP);
  assign pk_idle = (p_state_reg == P_IDLE);
  assign bus_mem_go = (b_state_reg == B_IDLE) & req & in_mem & pk_idle;
  assign avs_waitrequest = (b_state_reg != B_ACK);
  assign sw_req = (b_state_reg == B_IDLE) & avs_write &
                  (avs_address == `CANTX_REQ_OFS) & avs_writedata[0];

  // ----------------------------------------------------------------------
  // configuration memory, shared between bus and packer
  // ----------------------------------------------------------------------
  // the packer owns the port while busy; bus memory access then waits
  always @*
  begin
    mem_we = 1'b0;
    mem_addr = {sig_reg, word_reg};
    if (bus_mem_go)
    begin
      mem_addr = avs_address[6:2];
      mem_we = avs_write;
    end
  end

  cantx_cfg_mem u_cfg (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(avs_writedata),
    .q_reg(mem_q)
  );

  // ----------------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------------
  // every access answers after at least one wait cycle, memory reads two
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      b_state_reg <= B_IDLE;
      avs_readdata <= 32'h00000000;
      en_reg <= 1'b0;
      pgn_reg <= `CANTX_PGN_RST;
      rate_reg <= `CANTX_RATE_RST;
      lin_sel_reg <= 5'h00;
      pgn_rej_reg <= 1'b0;
    end
    else
    begin
      case (b_state_reg)
        B_IDLE:
        begin
          if (req && in_mem)
          begin
            if (pk_idle)
              b_state_reg <= avs_write ? B_ACK : B_MEM;
          end
          else if (req)
          begin
            b_state_reg <= B_ACK;
            avs_readdata <= 32'h00000000;
            if (avs_address == `CANTX_CTRL_OFS)
            begin
              if (avs_write)
                en_reg <= avs_writedata[0];
              avs_readdata <= {31'h0, en_reg};
            end
            else if (avs_address == `CANTX_PGN_OFS)
            begin
              // reserved group kept for internal use: refuse and flag
              if (avs_write && avs_writedata[17:0] == `CANTX_PGN_RSVD)
                pgn_rej_reg <= 1'b1;
              else if (avs_write)
                pgn_reg <= avs_writedata[17:0];
              avs_readdata <= {14'h0, pgn_reg};
            end
            else if (avs_address == `CANTX_RATE_OFS)
            begin
              if (avs_write)
                rate_reg <= avs_writedata[15:0];
              avs_readdata <= {16'h0, rate_reg};
            end
            else if (avs_address == `CANTX_LINSEL_OFS)
            begin
              if (avs_write)
                lin_sel_reg <= avs_writedata[4:0];
              avs_readdata <= {27'h0, lin_sel_reg};
            end
            else if (avs_address == `CANTX_STAT_OFS)
            begin
              if (avs_write && avs_writedata[0])
                pgn_rej_reg <= 1'b0;
              avs_readdata <= {29'h0, pend_reg, ~pk_idle, pgn_rej_reg};
            end
          end
        end
        B_MEM:
        begin
          avs_readdata <= mem_q;
          b_state_reg <= B_ACK;
        end
        default:
          b_state_reg <= B_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // triggers: period timer, software request, lin frame
  // ----------------------------------------------------------------------
  assign ms_tick = (ms_cnt_reg == MS_CYCLES - 1);
  assign per_trig = ms_tick && (rate_reg != 16'h0000) &&
                    (rate_cnt_reg + 16'h0001 >= rate_reg);
  assign lin_trig = lin_frame_done && (lin_sel_reg != 5'h00) &&
                    (lin_frame_num == lin_sel_reg);
  // packer may not grab the memory port while the bus is mid-read
  assign accept = pk_idle & pend_reg & ~bus_mem_go & (b_state_reg != B_MEM);

  // timers held at zero while disabled so the first period is whole
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_cnt_reg <= 32'h00000000;
      rate_cnt_reg <= 16'h0000;
      pend_reg <= 1'b0;
    end
    else
    begin
      if (!en_reg || rate_reg == 16'h0000 || ms_tick)
        ms_cnt_reg <= 32'h00000000;
      else
        ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
      if (!en_reg || rate_reg == 16'h0000 || per_trig)
        rate_cnt_reg <= 16'h0000;
      else if (ms_tick)
        rate_cnt_reg <= rate_cnt_reg + 16'h0001;
      // a new trigger wins over the clear on acceptance
      if (!en_reg)
        pend_reg <= 1'b0;
      else if (per_trig || lin_trig || sw_req)
        pend_reg <= 1'b1;
      else if (accept)
        pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // signal selection and encoding
  // ----------------------------------------------------------------------
  assign src = pos_reg[`CANTX_F_SRC];
  assign val = (src != 4'h0) ? snap_reg[{src[2:0] - 3'h1, 5'h00} +: 32]
                             : 32'h00000000;
  assign val_def = (src != 4'h0) && (src <= 4'h8) &&
                   snap_def_reg[src[2:0] - 3'h1];

  wire signed [32:0] cal_diff;
  wire signed [65:0] cal_prod;
  wire signed [49:0] cal_scaled;
  wire [31:0] cal_max;
  reg [31:0] code_next;

  // code = (value - offset) * gain / 65536, gain in 16.16 counts per unit
  assign cal_diff = $signed({val[31], val}) - $signed({ofs_reg[31], ofs_reg});
  assign cal_prod = cal_diff * $signed({1'b0, gain_reg});
  assign cal_scaled = cal_prod[65:16];
  assign cal_max = sat_max(pos_reg[`CANTX_F_SIZE]);

  always @*
  begin
    code_next = 32'hffffffff;
    if (val_def && pos_reg[`CANTX_F_TYPE] == `CANTX_T_DISC)
      code_next = val;
    else if (val_def && pos_reg[`CANTX_F_TYPE] == `CANTX_T_CONT)
    begin
      // clamp to the continuous range of the field width
      if (cal_scaled < 0)
        code_next = 32'h00000000;
      else if (cal_scaled > $signed({18'h0, cal_max}))
        code_next = cal_max;
      else
        code_next = cal_scaled[31:0];
    end
  end

  // ----------------------------------------------------------------------
  // packing sequencer
  // ----------------------------------------------------------------------
  wire [5:0] fld_start;
  wire [63:0] fld_mask;

  assign fld_start = start_bit(pos_reg);
  assign fld_mask = low_ones(pos_reg[`CANTX_F_SIZE]) << fld_start;
  assign tx_valid = (p_state_reg == P_SEND);

  // walks the five slots; overlapping fields simply overwrite in slot order
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p_state_reg <= P_IDLE;
      sig_reg <= 3'h0;
      word_reg <= 2'h0;
      pos_reg <= `CANTX_POS_RST;
      gain_reg <= `CANTX_GAIN_RST;
      ofs_reg <= `CANTX_OFS_RST;
      code_reg <= 32'h00000000;
      frame_reg <= 64'hffffffffffffffff;
      snap_reg <= 256'h0;
      snap_def_reg <= 8'h00;
      tx_pgn <= `CANTX_PGN_RST;
      tx_data <= 64'hffffffffffffffff;
    end
    else
    begin
      case (p_state_reg)
        P_IDLE:
        begin
          if (accept)
          begin
            snap_reg <= fb_data;
            snap_def_reg <= fb_defined;
            tx_pgn <= pgn_reg;
            frame_reg <= 64'hffffffffffffffff;
            sig_reg <= 3'h0;
            word_reg <= `CANTX_W_POS;
            p_state_reg <= P_FETCH;
          end
        end
        P_FETCH:
          p_state_reg <= P_LOAD;
        P_LOAD:
        begin
          if (word_reg == `CANTX_W_POS)
            pos_reg <= mem_q;
          else if (word_reg == `CANTX_W_GAIN)
            gain_reg <= mem_q;
          else
            ofs_reg <= mem_q;
          if (word_reg == `CANTX_W_OFS)
            p_state_reg <= P_CALC;
          else
          begin
            word_reg <= word_reg + 2'h1;
            p_state_reg <= P_FETCH;
          end
        end
        P_CALC:
        begin
          code_reg <= code_next;
          p_state_reg <= P_MERGE;
        end
        P_MERGE:
        begin
          // unused slots and illegal placements leave their bits at one
          if (src != 4'h0 && pos_ok(pos_reg))
            frame_reg <= (frame_reg & ~fld_mask) |
                         (({32'h0, code_reg} << fld_start) & fld_mask);
          word_reg <= `CANTX_W_POS;
          if (sig_reg == 3'h4)
            p_state_reg <= P_SEND;
          else
          begin
            sig_reg <= sig_reg + 3'h1;
            p_state_reg <= P_FETCH;
          end
        end
        P_SEND:
        begin
          tx_data <= frame_reg;
          if (tx_ready)
            p_state_reg <= P_IDLE;
        end
        default:
          p_state_reg <= P_IDLE;
      endcase
    end
  end

endmodule // cantx_packer

//--- cantx_packer_properties.sv
// checker for the transmit packer: bus timing, frame hand-off, enable
// bound to every cantx_packer instance; sees only the top-level ports
`timescale 1ns/1ps
module cantx_packer_props #(
  parameter MS_CYCLES = 10
) (
  input wire ref_clk,
  input wire arst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [255:0] fb_data,
  input wire [7:0] fb_defined,
  input wire lin_frame_done,
  input wire [4:0] lin_frame_num,
  input wire tx_valid,
  input wire tx_ready,
  input wire [17:0] tx_pgn,
  input wire [63:0] tx_data
);
  // --------------------------------------------------------------
  // helper state: request onset, enable shadow, idle-while-off count
  // --------------------------------------------------------------
  reg req_reg;
  reg ack_reg;
  reg en_reg;
  reg [7:0] off_reg;
  wire req = avs_read | avs_write;
  wire first = req & (~req_reg | ack_reg);

  // the count saturates so a long disabled stretch cannot wrap
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      req_reg <= 1'b0;
      ack_reg <= 1'b0;
      en_reg <= 1'b0;
      off_reg <= 8'h00;
    end
    else
    begin
      req_reg <= req;
      ack_reg <= req & ~avs_waitrequest;
      if (avs_write && !avs_waitrequest && avs_address == 10'h000)
        en_reg <= avs_writedata[0];
      off_reg <= en_reg ? 8'h00 : off_reg + {7'h00, off_reg != 8'h80};
    end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence ack_once;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence held_frame;
    tx_valid ##1 tx_valid && !tx_ready;
  endsequence

  chk_reg_answer: assert property (first && avs_address < 10'h100 |=> ack_once)
    else $error("register access not answered after one cycle");
  chk_bus_answer: assert property (first |-> ##[1:300] !avs_waitrequest)
    else $error("bus access never answered");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    (avs_address > 10'h17c || (avs_address > 10'h014 && avs_address < 10'h100))
    |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_pgn_legal: assert property (tx_valid |-> tx_pgn != 18'h0ef00)
    else $error("reserved group number sent");
  chk_data_hold: assert property (held_frame |=> $stable(tx_data))
    else $error("frame data moved while offered");
  chk_valid_release: assert property (tx_valid && tx_ready |=> (!tx_valid)[*8])
    else $error("frame offered again too soon");
  chk_disabled_quiet: assert property (off_reg == 8'h80 |-> !tx_valid)
    else $error("frame offered while disabled");
endmodule // cantx_packer_props

bind cantx_packer cantx_packer_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .fb_data(fb_data), .fb_defined(fb_defined),
  .lin_frame_done(lin_frame_done), .lin_frame_num(lin_frame_num),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pgn(tx_pgn),
  .tx_data(tx_data));

//--- cantx_sender_model.sv
// can frame sender seen from the packer: takes offered frames
// assumes one clock; ready never high in the first offered cycle
`timescale 1ns/1ps
module cantx_sender_model (
  input wire ref_clk,
  input wire rst_n,
  input wire tx_valid,
  output reg tx_ready,
  input wire [17:0] tx_pgn,
  input wire [63:0] tx_data,
  output int frame_cnt,
  output reg [63:0] cap_data,
  output reg [17:0] cap_pgn
);
  // random stalls; data is only taken once it has settled
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      tx_ready <= 1'b0;
      frame_cnt <= 0;
      cap_data <= 64'h0;
      cap_pgn <= 18'h0;
    end
    else if (tx_valid && tx_ready)
    begin
      cap_data <= tx_data;
      cap_pgn <= tx_pgn;
      frame_cnt <= frame_cnt + 1;
      tx_ready <= 1'b0;
    end
    else if (tx_valid)
      tx_ready <= ($urandom % 4) != 0;
endmodule // cantx_sender_model

//--- cantx_packer_tb.sv
// bench: packer, sender model and a reference frame builder
// assumes a 200 MHz ref_clk and a millisecond shortened to 10 cycles
`timescale 1ns/1ps
module cantx_packer_tb;
  reg ref_clk = 1'b0;
  reg arst_n = 1'b0;
  reg [9:0] avs_address = 10'h000;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [255:0] fb_data = 256'h0;
  reg [7:0] fb_defined = 8'hff;
  reg lin_frame_done = 1'b0;
  reg [4:0] lin_frame_num = 5'h00;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, tx_valid, tx_ready;
  wire [17:0] tx_pgn, cap_pgn;
  wire [63:0] tx_data, cap_data;
  int frm_cnt, taken, errors, n_checks;
  reg [31:0] m_pos [5], m_gain [5], m_ofs [5], rd, g, p;
  reg [17:0] m_pgn;
  reg [63:0] ex, used;

  always #2.5 ref_clk = ~ref_clk;

  cantx_packer #(.MS_CYCLES(10)) u_cantx_packer (.ref_clk(ref_clk),
    .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fb_data(fb_data), .fb_defined(fb_defined),
    .lin_frame_done(lin_frame_done), .lin_frame_num(lin_frame_num),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pgn(tx_pgn),
    .tx_data(tx_data));
  cantx_sender_model u_cantx_sender_model (.ref_clk(ref_clk),
    .rst_n(arst_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_pgn(tx_pgn), .tx_data(tx_data), .frame_cnt(frm_cnt),
    .cap_data(cap_data), .cap_pgn(cap_pgn));

  // --------------------------------------------------------------
  // shared tasks: compare, bus cycle, frame waits
  // --------------------------------------------------------------
  task chk(input [63:0] seen, input [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task bus(input bit w, input [9:0] a, input [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task frame(input [63:0] ed);
    int n;
    n = 0;
    while (frm_cnt == taken && n < 300)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(frm_cnt != taken, 1);
    chk(cap_data, ed);
    chk(cap_pgn, m_pgn);
    taken = frm_cnt;
  endtask

  task none(input int c);
    repeat (c) @(negedge ref_clk);
    chk(frm_cnt == taken, 1);
    taken = frm_cnt;
  endtask

  task lin(input [4:0] k);
    @(posedge ref_clk);
    lin_frame_done <= 1'b1;
    lin_frame_num <= k;
    @(posedge ref_clk);
    lin_frame_done <= 1'b0;
  endtask

  task slot(input int s, input [31:0] p, input [31:0] gn, input [31:0] o);
    m_pos[s] = p;
    m_gain[s] = gn;
    m_ofs[s] = o;
    bus(1, 10'(256 + s * 16), p);
    bus(1, 10'(260 + s * 16), gn);
    bus(1, 10'(264 + s * 16), o);
  endtask

  // frame bits a slot covers; none for a placement that is out of range
  function automatic [63:0] fmask(input [31:0] pw);
    int st, sz, by, bi;
    sz = pw[13:8];
    by = pw[19:16];
    bi = pw[23:20];
    st = (by - 1) * 8 + bi - 1;
    fmask = '0;
    if (sz >= 1 && sz <= 32 && by >= 1 && by <= 8 && bi >= 1 && bi <= 8 &&
        st + sz <= 64)
      fmask = ((64'h1 << sz) - 64'h1) << st;
  endfunction

  // reference frame; a later slot overwrites an earlier one
  function automatic [63:0] model(input [255:0] fb, input [7:0] df);
    reg [63:0] f;
    longint v, c, mx;
    int st, sz, src, by, bi;
    f = '1;
    for (int s = 0; s < 5; s++)
    begin
      src = m_pos[s][7:4];
      sz = m_pos[s][13:8];
      by = m_pos[s][19:16];
      bi = m_pos[s][23:20];
      st = (by - 1) * 8 + bi - 1;
      if (sz < 1 || sz > 32 || by < 1 || by > 8 || bi < 1 || bi > 8 ||
          st + sz > 64)
        continue;
      if (m_pos[s][1:0] == 2'h0 || src < 1 || src > 8 || !df[src - 1])
        c = -1;
      else if (m_pos[s][1:0] == 2'h1)
        c = fb[(src - 1) * 32 +: 32];
      else
      begin
        v = longint'($signed(fb[(src - 1) * 32 +: 32]));
        v = v - longint'($signed(m_ofs[s]));
        c = (v < 0) ? 0 : (v * m_gain[s]) >>> 16;
        mx = (sz >= 8) ? (64'hfb << (sz - 8)) - 1 : (64'h1 << sz) - 2;
        if (c > mx)
          c = mx;
      end
      for (int b = 0; b < sz; b++)
        f[st + b] = c[b];
    end
    return f;
  endfunction

  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: the whole run needs well under 10000 cycles
  initial
  begin
    #200000;
    errors++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hbcec));
    m_pgn = 18'h0ff01;
    for (int s = 0; s < 5; s++)
    begin
      m_pos[s] = 32'h00110100;
      m_gain[s] = 32'h00010000;
      m_ofs[s] = 32'h0;
    end
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(0, 10'h000, 0);
    chk(rd, 0);
    bus(0, 10'h008, 0);
    chk(rd, 1000);
    bus(0, 10'h00c, 0);
    chk(rd, 0);
    bus(0, 10'h018, 0);
    chk(rd, 0);
    for (int s = 0; s < 5; s++)
    begin
      bus(0, 10'(256 + s * 16), 0);
      chk(rd, 32'h00110100);
      bus(0, 10'(260 + s * 16), 0);
      chk(rd, 32'h00010000);
      bus(0, 10'(264 + s * 16), 0);
      chk(rd, 0);
    end
    $display("test reset values done");
    bus(1, 10'h014, 1);
    none(140);
    bus(1, 10'h008, 0);
    bus(1, 10'h000, 1);
    bus(1, 10'h014, 1);
    frame(model(fb_data, fb_defined));
    none(120);
    $display("test enable and request done");
    bus(1, 10'h004, 32'h0000ef00);
    bus(0, 10'h004, 0);
    chk(rd, m_pgn);
    bus(0, 10'h010, 0);
    chk(rd[0], 1);
    bus(1, 10'h010, 1);
    bus(0, 10'h010, 0);
    chk(rd[0], 0);
    m_pgn = 18'h0fe10;
    bus(1, 10'h004, m_pgn);
    $display("test group number done");
    repeat (12)
    begin
      used = '0;
      for (int s = 0; s < 5; s++)
      begin
        // redraw a placement that hits an earlier field, else drop it
        for (int t = 0; t < 16; t++)
        begin
          p = {8'h00, 4'(1 + $urandom % 8), 4'($urandom % 10), 2'h0,
            6'($urandom % 34), 4'($urandom % 9), 2'h0, 2'($urandom % 3)};
          if ((fmask(p) & used) == 64'h0)
            break;
        end
        if ((fmask(p) & used) != 64'h0)
          p[13:8] = 6'h00;
        used = used | fmask(p);
        g = ($urandom % 2) ? 32'h00020000 : 32'h00010000;
        slot(s, p, g, (g == 32'h00010000) ? $urandom % 256 : 0);
      end
      for (int i = 0; i < 8; i++)
        fb_data[i * 32 +: 32] <= $urandom >> ($urandom % 28);
      fb_defined <= 8'($urandom);
      @(posedge ref_clk);
      ex = model(fb_data, fb_defined);
      bus(1, 10'h014, 1);
      repeat (5) @(posedge ref_clk);
      fb_data <= ~fb_data;
      frame(ex);
    end
    $display("test random signals done");
    lin(0);
    lin(3);
    none(80);
    bus(1, 10'h00c, 3);
    lin(5);
    none(80);
    lin(3);
    frame(model(fb_data, fb_defined));
    $display("test lin trigger done");
    bus(1, 10'h00c, 0);
    bus(1, 10'h008, 2);
    frame(model(fb_data, fb_defined));
    bus(1, 10'h008, 0);
    repeat (150) @(negedge ref_clk);
    taken = frm_cnt;
    bus(1, 10'h000, 0);
    bus(1, 10'h014, 1);
    none(150);
    $display("test periodic done");
    end_of_test();
  end
endmodule // cantx_packer_tb
